// *** hdl/fp_subtract_and_root_flags.v ***
// Subtract, subtract-flags and square-root-flags execution block
// What this block does
// - Root query: opcode 111, latency 17, recovery 16, slot 2
// - Root query returns square-root exception vector
// - Query operations never touch control-word flags
// - Vector bits 0..6 flags, upper bits zero
// - Root query flushes denormal input, reports it
// - Rounding follows control-word rounding mode
// - Guard bit zero keeps destination unchanged
// - Difference: opcode 113, latency 3, slots 1,4
// - Difference writes first minus second operand
// - Denormal subtract input flushed, sets control flag
// - Denormal difference becomes zero, sets control flag
// - Difference exceptions set control-word flags
// - Control flags sticky, cleared only by write
// - Flags update with the destination write
// - Simultaneous flag updates OR together
// - False guard blocks both write and flags
// - Difference query: opcode 114, latency 3, slots 1,4
// - Difference query returns subtract exception vector
// - Difference query flushes denormal inputs, reports it
// - Difference query reports denormal result flush
`timescale 1ns/1ps
`include "fp_subtract_and_root_flags_regs.vh"
module fp_subtract_and_root_flags (
  // Clock, reset, clock enable
  input wire i_clk,
  input wire i_rst_n,
  input wire i_ce,
  // Rounding mode held in the control word
  input wire [1:0] i_round_mode,
  // Adder unit issue
  input wire i_add_valid,
  input wire [7:0] i_add_opcode,
  input wire [2:0] i_add_slot,
  input wire [31:0] i_add_src1,
  input wire [31:0] i_add_src2,
  input wire i_add_guard_en,
  input wire [31:0] i_add_guard,
  input wire [6:0] i_add_dest,
  // Long-latency unit issue
  input wire i_root_valid,
  input wire [7:0] i_root_opcode,
  input wire [2:0] i_root_slot,
  input wire [31:0] i_root_src1,
  input wire i_root_guard_en,
  input wire [31:0] i_root_guard,
  input wire [6:0] i_root_dest,
  // Control word flag write and other units' flag updates
  input wire i_cw_write,
  input wire [6:0] i_cw_flags,
  input wire [6:0] i_other_flags,
  // Issue status
  output wire o_add_refused,
  output wire o_root_refused,
  output wire o_root_busy,
  // Adder unit destination write
  output reg o_add_wr_en,
  output reg [6:0] o_add_wr_dest,
  output reg [31:0] o_add_wr_data,
  // Long-latency unit destination write
  output reg o_root_wr_en,
  output reg [6:0] o_root_wr_dest,
  output reg [31:0] o_root_wr_data,
  // Control word exception flags
  output reg [6:0] o_cw_flags
);

  // -----------------------------------------------------------------
  // Square root step: one root bit from one radicand bit pair
  // -----------------------------------------------------------------
  function [53:0] root_step;
    input [27:0] rem;
    input [25:0] root;
    input [1:0] pair;
    reg [29:0] r;
    reg [29:0] t;
    begin
      r = {rem, pair};
      t = {2'b00, root, 2'b01};
      if (r >= t)
        root_step = {r[27:0] - t[27:0], root[24:0], 1'b1};
      else
        root_step = {r[27:0], root[24:0], 1'b0};
    end
  endfunction

  // -----------------------------------------------------------------
  // Adder unit
  // -----------------------------------------------------------------
  localparam ST_W = 49;
  wire [31:0] sub_result;
  wire [6:0] sub_flags;
  wire add_op_ok;
  wire add_slot_ok;
  wire add_take;
  wire add_we;
  reg [ST_W-1:0] add_st1;
  reg [ST_W-1:0] add_st2;
  wire st2_valid;
  wire st2_query;
  wire st2_we;
  wire [6:0] st2_dest;
  wire [31:0] st2_res;
  wire [6:0] st2_flags;
  wire add_commit;
  reg [6:0] next_cw_flags;

  // Arithmetic and flags, with the current rounding mode
  fp_sub_core u_sub (
    .i_a(i_add_src1),
    .i_b(i_add_src2),
    .i_round_mode(i_round_mode),
    .o_result(sub_result),
    .o_flags(sub_flags)
  );

  // Accept only own opcodes in slots 1 or 4
  assign add_op_ok = (i_add_opcode == `OP_DIFF) ||
                     (i_add_opcode == `OP_DIFF_QUERY);
  assign add_slot_ok = (i_add_slot == `SLOT_ADD_A) ||
                       (i_add_slot == `SLOT_ADD_B);
  assign add_take = i_add_valid & add_op_ok & add_slot_ok;
  assign o_add_refused = i_add_valid & ~add_take;
  assign add_we = ~i_add_guard_en | i_add_guard[0];

  // Stage fields
  assign st2_valid = add_st2[48];
  assign st2_query = add_st2[47];
  assign st2_we = add_st2[46];
  assign st2_dest = add_st2[45:39];
  assign st2_res = add_st2[38:7];
  assign st2_flags = add_st2[6:0];
  // Only a plain subtract whose guard is true or disabled reaches the control word
  assign add_commit = st2_valid & st2_we & ~st2_query;

  // Two pipeline stages then the output register: three cycles
  always @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      add_st1 <= {ST_W{1'b0}};
      add_st2 <= {ST_W{1'b0}};
      o_add_wr_en <= 1'b0;
      o_add_wr_dest <= 7'h00;
      o_add_wr_data <= 32'h0;
    end
    else if (i_ce)
    begin
      add_st1 <= {add_take, i_add_opcode == `OP_DIFF_QUERY, add_we,
                  i_add_dest, sub_result, sub_flags};
      add_st2 <= add_st1;
      o_add_wr_en <= st2_valid & st2_we;
      o_add_wr_dest <= st2_dest;
      if (st2_query)
        o_add_wr_data <= {25'h0, st2_flags};
      else
        o_add_wr_data <= st2_res;
    end
  end

  // -----------------------------------------------------------------
  // Control word exception flags
  // -----------------------------------------------------------------
  // Write first, then every set ORed in so a set beats a clear
  always @*
  begin
    next_cw_flags = o_cw_flags;
    if (i_cw_write)
      next_cw_flags = i_cw_flags;
    next_cw_flags = next_cw_flags | i_other_flags;
    if (add_commit)
      next_cw_flags = next_cw_flags | st2_flags;
  end

  // Loaded on the same edge as the adder output register
  always @(posedge i_clk)
  begin
    if (!i_rst_n)
      o_cw_flags <= `CW_FLAGS_RESET;
    else if (i_ce)
      o_cw_flags <= next_cw_flags;
  end

  // -----------------------------------------------------------------
  // Long-latency unit: square root exception query
  // -----------------------------------------------------------------
  localparam S_IDLE = 2'b01;
  localparam S_ROOT = 2'b10;
  reg [1:0] state;
  reg [4:0] cnt;
  reg [51:0] rt_x;
  reg [27:0] rt_rem;
  reg [25:0] rt_root;
  reg rt_odd;
  reg rt_iter;
  reg rt_we;
  reg [6:0] rt_dest;
  reg [6:0] rt_flags;
  reg r1_valid;
  reg r1_we;
  reg [6:0] r1_dest;
  reg [6:0] r1_flags;
  wire root_take;
  wire [7:0] re;
  wire [22:0] rf;
  wire r_zero;
  wire r_nan;
  wire r_inf;
  wire [6:0] pre_flags;
  wire [51:0] load_x;
  reg [53:0] step_a;
  reg [53:0] step_b;
  reg inexact;

  // Busy until recovery passes; issue while busy is refused
  assign o_root_busy = (state != S_IDLE);
  assign root_take = i_root_valid & ~o_root_busy &
                     (i_root_opcode == `OP_ROOT_QUERY) &
                     (i_root_slot == `SLOT_ROOT);
  assign o_root_refused = i_root_valid & ~root_take;

  // Operand classification at issue
  assign re = i_root_src1[30:23];
  assign rf = i_root_src1[22:0];
  assign r_zero = (re == 8'h00);
  assign r_nan = (re == `EXP_ALL_ONES) && (rf != 23'h0);
  assign r_inf = (re == `EXP_ALL_ONES) && (rf == 23'h0);
  assign pre_flags[`FLAG_DIV_ZERO] = 1'b0;
  assign pre_flags[`FLAG_ROUNDED] = 1'b0;
  assign pre_flags[`FLAG_TOO_SMALL] = 1'b0;
  assign pre_flags[`FLAG_TOO_LARGE] = 1'b0;
  // Signalling NaN or negative nonzero operand is invalid
  assign pre_flags[`FLAG_BAD_OP] = (r_nan & ~rf[22]) |
                                   (~r_nan & i_root_src1[31] & ~r_zero);
  assign pre_flags[`FLAG_IN_FLUSH] = r_zero & (rf != 23'h0);
  assign pre_flags[`FLAG_OUT_FLUSH] = 1'b0;
  // Radicand scaled by an even power so the root is an integer
  assign load_x = re[0] ? {1'b0, 1'b1, rf, 27'h0} :
                          {2'b00, 1'b1, rf, 26'h0};

  // Two root bits per cycle, exactness check at the end
  always @*
  begin
    step_a = root_step(rt_rem, rt_root, rt_x[51:50]);
    step_b = root_step(step_a[53:26], step_a[25:0], rt_x[49:48]);
    inexact = (rt_rem != 28'h0) ||
              (rt_odd ? (rt_root[1:0] != 2'b00) : rt_root[0]);
  end

  // Sequencer: steps in cycles 1..13, result staged in cycle 15
  always @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      state <= S_IDLE;
      cnt <= 5'h00;
      rt_x <= 52'h0;
      rt_rem <= 28'h0;
      rt_root <= 26'h0;
      rt_odd <= 1'b0;
      rt_iter <= 1'b0;
      rt_we <= 1'b0;
      rt_dest <= 7'h00;
      rt_flags <= 7'h00;
      r1_valid <= 1'b0;
      r1_we <= 1'b0;
      r1_dest <= 7'h00;
      r1_flags <= 7'h00;
    end
    else if (i_ce)
    begin
      r1_valid <= 1'b0;
      case (state)
        S_IDLE:
        begin
          if (root_take)
          begin
            state <= S_ROOT;
            cnt <= 5'h01;
            rt_x <= load_x;
            rt_rem <= 28'h0;
            rt_root <= 26'h0;
            rt_odd <= re[0];
            rt_iter <= ~r_zero & ~r_nan & ~r_inf & ~i_root_src1[31];
            rt_we <= ~i_root_guard_en | i_root_guard[0];
            rt_dest <= i_root_dest;
            rt_flags <= pre_flags;
          end
        end
        S_ROOT:
        begin
          cnt <= cnt + 5'h01;
          if (cnt <= `ROOT_STEPS)
          begin
            rt_rem <= step_b[53:26];
            rt_root <= step_b[25:0];
            rt_x <= {rt_x[47:0], 4'h0};
          end
          if (cnt == `ROOT_FINISH)
          begin
            state <= S_IDLE;
            r1_valid <= 1'b1;
            r1_we <= rt_we;
            r1_dest <= rt_dest;
            r1_flags <= rt_flags |
                        ({6'h00, rt_iter & inexact} << `FLAG_ROUNDED);
          end
        end
        default:
          state <= S_IDLE;
      endcase
    end
  end

  // Destination write in cycle 17; control word is never touched
  always @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      o_root_wr_en <= 1'b0;
      o_root_wr_dest <= 7'h00;
      o_root_wr_data <= 32'h0;
    end
    else if (i_ce)
    begin
      o_root_wr_en <= r1_valid & r1_we;
      o_root_wr_dest <= r1_dest;
      o_root_wr_data <= {25'h0, r1_flags};
    end
  end

endmodule

// *** hdl/fp_subtract_and_root_flags_regs.vh ***
// Constants for the subtract and square-root-flags execution block
`ifndef FP_SUBTRACT_AND_ROOT_FLAGS_REGS_VH
`define FP_SUBTRACT_AND_ROOT_FLAGS_REGS_VH

// -----------------------------------------------------------------
// Operation codes and issue slots
// -----------------------------------------------------------------
`define OP_ROOT_QUERY 8'h6f
`define OP_DIFF 8'h71
`define OP_DIFF_QUERY 8'h72
`define SLOT_ROOT 3'h2
`define SLOT_ADD_A 3'h1
`define SLOT_ADD_B 3'h4

// -----------------------------------------------------------------
// Timing in core clock cycles
// -----------------------------------------------------------------
`define ADD_LATENCY 5'h03
`define ROOT_LATENCY 5'h11
`define ROOT_RECOVERY 5'h10
`define ROOT_STEPS 5'h0d
`define ROOT_FINISH (`ROOT_RECOVERY - 5'h01)

// -----------------------------------------------------------------
// Exception vector bit positions and reset value
// -----------------------------------------------------------------
`define FLAGS_W 7
`define FLAG_DIV_ZERO 0
`define FLAG_ROUNDED 1
`define FLAG_TOO_SMALL 2
`define FLAG_TOO_LARGE 3
`define FLAG_BAD_OP 4
`define FLAG_IN_FLUSH 5
`define FLAG_OUT_FLUSH 6
`define CW_FLAGS_RESET 7'h00

// -----------------------------------------------------------------
// Rounding modes and special values
// -----------------------------------------------------------------
`define RM_NEAREST 2'h0
`define RM_DOWN 2'h1
`define RM_UP 2'h2
`define RM_ZERO 2'h3
`define QUIET_NAN 32'hffffffff
`define EXP_ALL_ONES 8'hff

`endif

// *** hdl/fp_sub_core.v ***
// Single-precision subtract with flush-to-zero and flags
`timescale 1ns/1ps
`include "fp_subtract_and_root_flags_regs.vh"
module fp_sub_core (
  // Operands and rounding mode
  input wire [31:0] i_a,
  input wire [31:0] i_b,
  input wire [1:0] i_round_mode,
  // Difference and exception vector
  output reg [31:0] o_result,
  output reg [6:0] o_flags
);

  // Leading zero count
  function [4:0] lead_zeros;
    input [26:0] v;
    integer i;
    reg found;
    begin
      lead_zeros = 5'h00;
      found = 1'b0;
      for (i = 26; i >= 0; i = i - 1)
        if (!found)
        begin
          if (v[i])
            found = 1'b1;
          else
            lead_zeros = lead_zeros + 5'h01;
        end
    end
  endfunction

  reg [7:0] ea, eb, ex, ey, d;
  reg sa, sb, sign, big, na, nb, ia, ib, za, zb, rounded_flag, up;
  reg [23:0] mx, my;
  reg [26:0] al, man;
  reg [27:0] sum;
  reg [9:0] e;
  reg [4:0] lz;
  reg [24:0] rnd;
  reg [22:0] frac;

  // Classify operands, second one negated
  always @*
  begin
    ea = i_a[30:23];
    eb = i_b[30:23];
    sa = i_a[31];
    sb = ~i_b[31];
    na = (ea == `EXP_ALL_ONES) && (i_a[22:0] != 23'h0);
    nb = (eb == `EXP_ALL_ONES) && (i_b[22:0] != 23'h0);
    ia = (ea == `EXP_ALL_ONES) && !na;
    ib = (eb == `EXP_ALL_ONES) && !nb;
    za = (ea == 8'h00);
    zb = (eb == 8'h00);
    big = (i_a[30:0] >= i_b[30:0]);
    ex = big ? ea : eb;
    ey = big ? eb : ea;
    sign = big ? sa : sb;
    mx = big ? {1'b1, i_a[22:0]} : {1'b1, i_b[22:0]};
    my = big ? {1'b1, i_b[22:0]} : {1'b1, i_a[22:0]};
    d = ex - ey;
    // Align smaller operand, keep a sticky bit
    if (d >= 8'd27)
      al = 27'h1;
    else
    begin
      al = {my, 3'b000} >> d;
      al[0] = al[0] | (|({my, 3'b000} & ~({27{1'b1}} << d)));
    end
    if (sa == sb)
      sum = {1'b0, mx, 3'b000} + {1'b0, al};
    else
      sum = {1'b0, mx, 3'b000} - {1'b0, al};
    e = {2'b00, ex};
    lz = lead_zeros(sum[26:0]);
    if (sum[27])
    begin
      man = {sum[27:2], sum[1] | sum[0]};
      e = e + 10'd1;
    end
    else
    begin
      man = sum[26:0] << lz;
      e = e - {5'h00, lz};
    end
    // Rounding by the control word mode
    rounded_flag = |man[2:0];
    case (i_round_mode)
      `RM_NEAREST: up = man[2] & ((|man[1:0]) | man[3]);
      `RM_UP: up = ~sign & rounded_flag;
      `RM_DOWN: up = sign & rounded_flag;
      default: up = 1'b0;
    endcase
    rnd = {1'b0, man[26:3]} + {24'h0, up};
    frac = rnd[24] ? 23'h0 : rnd[22:0];
    if (rnd[24])
      e = e + 10'd1;
    // Result selection, specials first
    o_flags = 7'h00;
    o_flags[`FLAG_IN_FLUSH] = (za && i_a[22:0] != 23'h0) ||
                              (zb && i_b[22:0] != 23'h0);
    o_result = 32'h0;
    if (na || nb)
    begin
      o_result = `QUIET_NAN;
      o_flags[`FLAG_BAD_OP] = (na & ~i_a[22]) | (nb & ~i_b[22]);
    end
    else if (ia && ib && sa != sb)
    begin
      o_result = `QUIET_NAN;
      o_flags[`FLAG_BAD_OP] = 1'b1;
    end
    else if (ia)
      o_result = {sa, `EXP_ALL_ONES, 23'h0};
    else if (ib)
      o_result = {sb, `EXP_ALL_ONES, 23'h0};
    else if (za && zb)
      o_result = {(sa == sb) ? sa : (i_round_mode == `RM_DOWN), 31'h0};
    else if (za)
      o_result = {sb, i_b[30:0]};
    else if (zb)
      o_result = i_a;
    else if (sum == 28'h0)
      o_result = {i_round_mode == `RM_DOWN, 31'h0};
    else if (!e[9] && e[8:0] >= 9'd255)
    begin
      o_flags[`FLAG_TOO_LARGE] = 1'b1;
      o_flags[`FLAG_ROUNDED] = 1'b1;
      if (i_round_mode == `RM_NEAREST ||
          (i_round_mode == `RM_UP && !sign) ||
          (i_round_mode == `RM_DOWN && sign))
        o_result = {sign, `EXP_ALL_ONES, 23'h0};
      else
        o_result = {sign, 8'hfe, 23'h7fffff};
    end
    else if (e[9] || e == 10'd0)
    begin
      // Tiny result flushed to signed zero
      o_result = {sign, 31'h0};
      o_flags[`FLAG_OUT_FLUSH] = 1'b1;
      o_flags[`FLAG_TOO_SMALL] = 1'b1;
      o_flags[`FLAG_ROUNDED] = 1'b1;
    end
    else
    begin
      o_result = {sign, e[7:0], frac};
      o_flags[`FLAG_ROUNDED] = rounded_flag;
    end
  end

endmodule

// *** bench/fp_sub_root_sva.sv ***
// Issue timing and flag checker
`timescale 1ns/1ps
`include "fp_subtract_and_root_flags_regs.vh"
module fp_sub_root_sva (
  // Clock and reset
  input wire i_clk,
  input wire i_rst_n,
  // Issue inputs
  input wire i_add_valid,
  input wire [7:0] i_add_opcode,
  input wire [2:0] i_add_slot,
  input wire i_add_guard_en,
  input wire [31:0] i_add_guard,
  input wire i_root_valid,
  input wire [7:0] i_root_opcode,
  input wire [2:0] i_root_slot,
  input wire i_root_guard_en,
  input wire [31:0] i_root_guard,
  input wire i_cw_write,
  input wire [6:0] i_cw_flags,
  input wire [6:0] i_other_flags,
  // Outputs watched
  input wire o_root_refused,
  input wire o_root_busy,
  input wire o_add_wr_en,
  input wire [31:0] o_add_wr_data,
  input wire o_root_wr_en,
  input wire [31:0] o_root_wr_data,
  input wire [6:0] o_cw_flags
);
  // ------------------------------------------------------------
  // Accepted issues
  // ------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  wire add_fire = i_add_valid && (!i_add_guard_en || i_add_guard[0]) &&
    (i_add_opcode == `OP_DIFF || i_add_opcode == `OP_DIFF_QUERY) &&
    (i_add_slot == `SLOT_ADD_A || i_add_slot == `SLOT_ADD_B);
  wire root_fire = i_root_valid && !o_root_busy &&
    i_root_opcode == `OP_ROOT_QUERY && i_root_slot == `SLOT_ROOT &&
    (!i_root_guard_en || i_root_guard[0]);
  // Recovery window of the long unit
  sequence busy_run;
    o_root_busy [*8] ##7 o_root_busy;
  endsequence
  sequence unit_free;
    !o_root_busy;
  endsequence
  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  add_latency_a: assert property (add_fire |-> ##3 o_add_wr_en)
    else $error("adder latency");
  add_cause_a: assert property (o_add_wr_en |-> $past(add_fire, 3))
    else $error("adder cause");
  root_latency_a: assert property (root_fire |-> ##17 o_root_wr_en)
    else $error("root latency");
  root_busy_a: assert property (root_fire |=> busy_run ##1
    unit_free) else $error("root recovery");
  busy_refuse_a: assert property (o_root_busy && i_root_valid |->
    o_root_refused) else $error("busy issue taken");
  root_vector_a: assert property (o_root_wr_en |->
    o_root_wr_data[31:7] == 25'h0) else $error("root vector");
  query_vector_a: assert property (o_add_wr_en &&
    $past(i_add_opcode, 3) == `OP_DIFF_QUERY |->
    o_add_wr_data[31:7] == 25'h0) else $error("query vector");
  flags_sticky_a: assert property (!$past(i_cw_write) |->
    (o_cw_flags & $past(o_cw_flags)) == $past(o_cw_flags))
    else $error("flag cleared");
  flags_or_a: assert property (|i_other_flags |=>
    (o_cw_flags & $past(i_other_flags)) == $past(i_other_flags))
    else $error("flag set lost");
  flags_cause_a: assert property (o_cw_flags !=
    $past(o_cw_flags) |-> $past(i_cw_write) || $past(i_other_flags) != 7'h00
    || (o_add_wr_en && $past(i_add_opcode, 3) == `OP_DIFF))
    else $error("flags uncaused");
  cw_write_a: assert property (i_cw_write &&
    i_other_flags == 7'h00 ##1 !o_add_wr_en |->
    o_cw_flags == $past(i_cw_flags)) else $error("write lost");
endmodule

// *** bench/issue_regfile_model.sv ***
// Issue-side register file fed by the result ports
`timescale 1ns/1ps
module issue_regfile_model (
  // Clock
  input wire i_clk,
  // Result writes
  input wire i_add_wr_en,
  input wire [6:0] i_add_wr_dest,
  input wire [31:0] i_add_wr_data,
  input wire i_root_wr_en,
  input wire [6:0] i_root_wr_dest,
  input wire [31:0] i_root_wr_data
);
  logic [31:0] rf [0:127];
  // Known fill so a skipped write shows
  initial
  begin
    for (int n = 0; n < 128; n++)
      rf[n] = 32'ha5a5a5a5 ^ 32'(n);
  end
  // Result writes
  always @(posedge i_clk)
  begin
    if (i_add_wr_en === 1'b1)
      rf[i_add_wr_dest] <= i_add_wr_data;
    if (i_root_wr_en === 1'b1)
      rf[i_root_wr_dest] <= i_root_wr_data;
  end
endmodule

// *** bench/fp_subtract_and_root_flags_test.sv ***
// Testbench for the subtract and root-flags block
`timescale 1ns/1ps
`include "fp_subtract_and_root_flags_regs.vh"
module fp_subtract_and_root_flags_test;
  // ------------------------------------------------------------
  // Signals and case tables
  // ------------------------------------------------------------
  logic i_clk, i_rst_n, i_ce, i_add_valid, i_add_guard_en;
  logic i_root_valid, i_root_guard_en, i_cw_write;
  logic [1:0] i_round_mode;
  logic [7:0] i_add_opcode, i_root_opcode;
  logic [2:0] i_add_slot, i_root_slot;
  logic [31:0] i_add_src1, i_add_src2, i_add_guard;
  logic [31:0] i_root_src1, i_root_guard;
  logic [6:0] i_add_dest, i_root_dest, i_cw_flags, i_other_flags;
  wire o_add_refused, o_root_refused, o_root_busy;
  wire o_add_wr_en, o_root_wr_en;
  wire [6:0] o_add_wr_dest, o_root_wr_dest, o_cw_flags;
  wire [31:0] o_add_wr_data, o_root_wr_data;
  int err_total, tests_run, cyc;
  logic [31:0] ta [0:8] = '{32'h40400000, 32'hc0400000, 32'h40400000,
    32'h40400000, 32'h00c00000, 32'h7f800000, 32'h7f7fffff,
    32'h7f7fffff, 32'hffbfffff};
  logic [31:0] tb [0:8] = '{32'hc0400000, 32'h3f800000, 32'h00800000,
    32'h00400000, 32'h00800000, 32'h7f800000, 32'hff7fffff,
    32'hff7fffff, 32'h3f800000};
  logic [31:0] tr [0:8] = '{32'h40c00000, 32'hc0800000, 32'h40400000,
    32'h40400000, 32'h00000000, 32'hffffffff, 32'h7f800000,
    32'h7f7fffff, 32'hffffffff};
  logic [6:0] tf [0:8] = '{7'h00, 7'h00, 7'h02, 7'h20, 7'h46, 7'h10,
    7'h0a, 7'h0a, 7'h10};
  logic [31:0] ra [0:4] = '{32'h40400000, 32'h00400000, 32'hc0400000,
    32'h7f800000, 32'h7f7fffff};
  logic [6:0] rx [0:4] = '{7'h02, 7'h20, 7'h10, 7'h00, 7'h02};

  // Block, issue-side model
  fp_subtract_and_root_flags i_fp_subtract_and_root_flags (.*);
  issue_regfile_model i_issue_regfile_model (.i_clk(i_clk),
    .i_add_wr_en(o_add_wr_en), .i_add_wr_dest(o_add_wr_dest),
    .i_add_wr_data(o_add_wr_data), .i_root_wr_en(o_root_wr_en),
    .i_root_wr_dest(o_root_wr_dest), .i_root_wr_data(o_root_wr_data));

  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] e, g);
    tests_run++;
    if (g !== e)
    begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic conclude;
    $display("Checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // Control-word write
  task automatic cw_set(input logic [6:0] v, oth);
    @(posedge i_clk);
    i_cw_write <= 1'b1;
    i_cw_flags <= v;
    i_other_flags <= oth;
    @(posedge i_clk);
    i_cw_write <= 1'b0;
    #1;
  endtask
  // Adder issue; returns when the result is due
  task automatic add1(input logic [7:0] op, input logic [31:0] a, b,
    input logic [1:0] rm, input logic ge, g0, input logic [2:0] sl,
    input logic [6:0] d);
    @(posedge i_clk);
    i_add_valid <= 1'b1;
    i_add_opcode <= op;
    i_add_src1 <= a;
    i_add_src2 <= b;
    i_round_mode <= rm;
    i_add_guard_en <= ge;
    i_add_guard <= {31'h7fffffff, g0};
    i_add_slot <= sl;
    i_add_dest <= d;
    @(posedge i_clk);
    i_add_valid <= 1'b0;
    repeat (2) @(posedge i_clk);
    #1;
  endtask
  // Root-flags issue; k is edges to result
  task automatic root1(input logic [31:0] a, input logic g0,
    input logic [6:0] d, output int k);
    @(posedge i_clk);
    i_root_valid <= 1'b1;
    i_root_opcode <= `OP_ROOT_QUERY;
    i_root_slot <= `SLOT_ROOT;
    i_root_src1 <= a;
    i_root_guard_en <= 1'b1;
    i_root_guard <= {31'h7fffffff, g0};
    i_root_dest <= d;
    @(posedge i_clk);
    i_root_valid <= 1'b0;
    #1;
    k = 0;
    while (k < 20 && o_root_wr_en !== 1'b1)
    begin
      @(posedge i_clk);
      #1;
      k++;
    end
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  // Case table, subtract then query; case 7 rounds to zero
  task automatic t_table;
    for (int j = 0; j < 2; j++)
      for (int i = 0; i < 9; i++)
      begin
        cw_set(7'h00, 7'h00);
        add1(j ? `OP_DIFF_QUERY : `OP_DIFF, ta[i], tb[i], {2{i == 7}}, 1'b0,
          1'b0, i[0] ? `SLOT_ADD_A : `SLOT_ADD_B, 7'(i));
        chk("add wr", 1, o_add_wr_en);
        chk("add data", j ? {25'h0, tf[i]} : tr[i], o_add_wr_data);
        chk("cw flags", j ? 7'h00 : tf[i], o_cw_flags);
      end
  endtask
  // False guard blocks destination and flags
  task automatic t_guard;
    cw_set(7'h00, 7'h00);
    add1(`OP_DIFF, 32'h40400000, 32'h00400000, 2'h0, 1'b1, 1'b0,
      `SLOT_ADD_A, 7'd20);
    chk("guard wr", 0, o_add_wr_en);
    @(posedge i_clk);
    #1;
    chk("guard rf", 32'ha5a5a5a5 ^ 32'd20,
      i_issue_regfile_model.rf[20]);
    chk("guard cw", 0, o_cw_flags);
    add1(`OP_DIFF, 32'h40400000, 32'h00400000, 2'h0, 1'b1, 1'b1,
      `SLOT_ADD_B, 7'd21);
    chk("true wr", 1, o_add_wr_en);
    chk("true cw", 7'h20, o_cw_flags);
  endtask
  // Wrong opcode, wrong slot
  task automatic t_refuse;
    for (int k = 0; k < 2; k++)
    begin
      @(posedge i_clk);
      i_add_valid <= 1'b1;
      i_add_opcode <= k ? `OP_DIFF : 8'h70;
      i_add_slot <= k ? 3'h2 : `SLOT_ADD_A;
      #1;
      chk("refused", 1, o_add_refused);
      @(posedge i_clk);
      i_add_valid <= 1'b0;
      repeat (2) @(posedge i_clk);
      #1;
      chk("refused wr", 0, o_add_wr_en);
    end
  endtask
  // Sticky flags and simultaneous sets
  task automatic t_sticky;
    cw_set(7'h7f, 7'h00);
    chk("cw all", 7'h7f, o_cw_flags);
    add1(`OP_DIFF, 32'h40400000, 32'hc0400000, 2'h0, 1'b0, 1'b0,
      `SLOT_ADD_A, 7'd30);
    chk("cw kept", 7'h7f, o_cw_flags);
    cw_set(7'h00, 7'h08);
    chk("set wins", 7'h08, o_cw_flags);
    i_other_flags <= 7'h01;
    add1(`OP_DIFF, 32'h40400000, 32'h00400000, 2'h0, 1'b0, 1'b0,
      `SLOT_ADD_B, 7'd31);
    chk("or set", 7'h29, o_cw_flags);
    @(posedge i_clk);
    i_other_flags <= 7'h00;
  endtask
  // Busy window refusal and earliest next issue
  task automatic t_busy;
    @(posedge i_clk);
    i_root_valid <= 1'b1;
    i_root_opcode <= `OP_ROOT_QUERY;
    i_root_slot <= `SLOT_ROOT;
    i_root_src1 <= 32'h40400000;
    i_root_dest <= 7'd40;
    @(posedge i_clk);
    i_root_valid <= 1'b0;
    repeat (4) @(posedge i_clk);
    i_root_valid <= 1'b1;
    i_root_src1 <= 32'hc0400000;
    i_root_dest <= 7'd41;
    #1;
    chk("busy refused", 1, o_root_refused);
    @(posedge i_clk);
    i_root_valid <= 1'b0;
    repeat (10) @(posedge i_clk);
    i_root_valid <= 1'b1;
    i_root_src1 <= 32'h00400000;
    i_root_dest <= 7'd42;
    #1;
    chk("free busy", 0, o_root_busy);
    chk("free taken", 0, o_root_refused);
    @(posedge i_clk);
    i_root_valid <= 1'b0;
    #1;
    chk("first wr", 1, o_root_wr_en);
    chk("first vec", 32'h2, o_root_wr_data);
    repeat (16) @(posedge i_clk);
    #1;
    chk("second vec", 32'h20, o_root_wr_data);
    chk("drop rf", 32'ha5a5a5a5 ^ 32'd41,
      i_issue_regfile_model.rf[41]);
  endtask
  // Root-flags cases, guard false, flag word untouched
  task automatic t_root;
    int k;
    cw_set(7'h00, 7'h00);
    for (int i = 0; i < 5; i++)
    begin
      root1(ra[i], 1'b1, 7'(50 + i), k);
      chk("root lat", 16, 32'(k));
      chk("root vec", {25'h0, rx[i]}, o_root_wr_data);
    end
    root1(32'h40400000, 1'b0, 7'd60, k);
    chk("guard lat", 20, 32'(k));
    chk("root rf", 32'h2, i_issue_regfile_model.rf[50]);
    chk("root rf kept", 32'ha5a5a5a5 ^ 32'd60,
      i_issue_regfile_model.rf[60]);
    chk("root cw", 0, o_cw_flags);
  endtask

  // ------------------------------------------------------------
  // Clock, timeout, main sequence
  // ------------------------------------------------------------
  initial
  begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end
  // Cut a hang short
  always @(posedge i_clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      err_total++;
      conclude;
    end
  end
  // Reset, then the scenarios
  initial
  begin
    {i_rst_n, i_add_valid, i_root_valid, i_cw_write} = 4'h0;
    {i_add_guard_en, i_root_guard_en, i_round_mode} = 4'h0;
    {i_add_opcode, i_root_opcode, i_add_slot, i_root_slot} = 22'h0;
    {i_add_src1, i_add_src2, i_add_guard} = 96'h0;
    {i_root_src1, i_root_guard} = 64'h0;
    {i_add_dest, i_root_dest, i_cw_flags, i_other_flags} = 28'h0;
    i_ce = 1'b1;
    repeat (6) @(posedge i_clk);
    i_rst_n <= 1'b1;
    t_table;
    t_guard;
    t_refuse;
    t_sticky;
    t_busy;
    t_root;
    conclude;
  end
endmodule

// Checker attached to the block's ports
bind fp_subtract_and_root_flags fp_sub_root_sva i_fp_sub_root_sva (.*);
